// [dv/rofs_relay_load.sv]
/*
 relay load model: two coils fed by the relay outputs, and contacts that
 switch a fixed number of clock cycles after the coil level changes.
 assumes the coil levels are synchronous to clk_i; PICKUP is 2 or more.
*/
`timescale 1ns/100ps
module rofs_relay_load
#(
    parameter int PICKUP = 2
)(
    input  wire logic clk_i,
    input  wire logic board_coil_i,
    input  wire logic card_coil_i,
    output logic      board_contact_o,
    output logic      card_contact_o
);
    // a real contact lags its coil, so the bench cannot judge the contact in the coil's cycle
    logic [PICKUP-1:0] board_dly_ff;
    logic [PICKUP-1:0] card_dly_ff;

    always_ff @(posedge clk_i)
    begin
        board_dly_ff <= {board_dly_ff[PICKUP-2:0], board_coil_i};
        card_dly_ff  <= {card_dly_ff[PICKUP-2:0], card_coil_i};
    end

    assign board_contact_o = board_dly_ff[PICKUP-1];
    assign card_contact_o  = card_dly_ff[PICKUP-1];
endmodule : rofs_relay_load

// [dv/rofs_top_bench.sv]
/*
 self-checking bench for the relay output function selector top.
 assumes classic wishbone with one-cycle ack and one-cycle output latency.
*/
`timescale 1ns/100ps
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module rofs_top_bench
    import rofs_pkg::*;
;
    logic              clk;
    logic              rst;
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADR_W-1:0]  adr;
    logic [3:0]        sel;
    logic [31:0]       wdat;
    logic [31:0]       rdat;
    logic              ack;
    logic              running;
    logic              fault;
    logic [FREQ_W-1:0] freq;
    logic [FREQ_W-1:0] target;
    logic [FREQ_W-1:0] maxf;
    logic [COND_N-1:0] cond;
    logic              board;
    logic              card;
    logic              irq;
    logic              board_contact;
    logic              card_contact;
    logic [31:0]       rd;
    int                n_fail;
    int                cmp_count;

    rofs_top u_rofs_top (
        .core_clk_i          (clk),
        .rst_i               (rst),
        .wb_cyc_i            (cyc),
        .wb_stb_i            (stb),
        .wb_we_i             (we),
        .wb_adr_i            (adr),
        .wb_sel_i            (sel),
        .wb_dat_i            (wdat),
        .wb_dat_o            (rdat),
        .wb_ack_o            (ack),
        .drive_running_i     (running),
        .fault_stop_i        (fault),
        .run_freq_i          (freq),
        .target_freq_i       (target),
        .max_freq_i          (maxf),
        .status_cond_i       (cond),
        .board_relay_output_o(board),
        .card_relay_output_o (card),
        .irq_o               (irq)
    );

    rofs_relay_load u_rofs_relay_load (
        .clk_i          (clk),
        .board_coil_i   (board),
        .card_coil_i    (card),
        .board_contact_o(board_contact),
        .card_contact_o (card_contact)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic tally_and_finish;
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // one classic cycle; request held until ack is seen high at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (ack !== 1'b1)
        begin
            n_fail++;
            tally_and_finish();
        end
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        wb(1'b0, a, 32'h0000_0000);
    endtask : rdr

    task automatic settle;
        repeat (3) @(posedge clk);
    endtask : settle

    task automatic t_reset;
        rdr(OFS_BOARD_SEL);
        `CHK(rd[15:0], RST_BOARD_SEL)
        rdr(OFS_CARD_SEL);
        `CHK(rd[15:0], RST_CARD_SEL)
        fault   <= 1'b1;
        running <= 1'b1;
        settle();
        `CHK(board, 1'b1)
        `CHK(card, 1'b0)
        fault <= 1'b0;
        settle();
        `CHK(board, 1'b0)
        running <= 1'b0;
    endtask : t_reset

    task automatic t_run;
        wr(OFS_CARD_SEL, {16'h0000, CODE_RUN});
        running <= 1'b1;
        settle();
        `CHK(card, 1'b1)
        repeat (2) @(posedge clk);
        `CHK(card_contact, 1'b1)
        wr(OFS_CARD_SEL, {16'h0000, CODE_NONE});
        @(posedge clk);
        `CHK(card, 1'b0)
    endtask : t_run

    // frequency sweeps below: four values packed high to low, expected level per bit
    task automatic t_fdt;
        logic [63:0] fv;
        logic [3:0]  ev;
        fv = {16'h03e8, 16'h03e9, 16'h0384, 16'h0383};
        ev = 4'b0110;
        wr(OFS_DET_VAL, 32'h0000_03e8);
        wr(OFS_HYST, 32'h0000_0064);
        wr(OFS_BOARD_SEL, {16'h0000, CODE_FREQ_LVL});
        for (int i = 3; i >= 0; i--)
        begin
            freq <= fv[16*i +: 16];
            settle();
            `CHK(board, ev[i])
        end
        freq <= 16'h03e9;
        settle();
        freq <= 16'h0384;
        settle();
        rdr(OFS_LEVEL);
        `CHK(rd[2:0], 3'h5)
        `CHK(board_contact, 1'b1)
    endtask : t_fdt

    task automatic t_reach;
        logic [63:0] fv;
        logic [3:0]  ev;
        fv = {16'h01c1, 16'h01c2, 16'h0226, 16'h0227};
        ev = 4'b0110;
        target <= 16'h01f4;
        maxf   <= 16'h03e8;
        wr(OFS_REACH, 32'h0000_0032);
        wr(OFS_BOARD_SEL, {16'h0000, CODE_REACH});
        for (int i = 3; i >= 0; i--)
        begin
            freq <= fv[16*i +: 16];
            settle();
            `CHK(board, ev[i])
        end
    endtask : t_reach

    task automatic t_zero;
        wr(OFS_CARD_SEL, {16'h0000, CODE_ZERO_RUN});
        freq <= 16'h0000;
        settle();
        `CHK(card, 1'b1)
        freq <= 16'h0005;
        settle();
        `CHK(card, 1'b0)
        freq <= 16'h0000;
        settle();
        `CHK(card, 1'b1)
        running <= 1'b0;
        settle();
        `CHK(card, 1'b0)
    endtask : t_zero

    task automatic t_codes;
        wr(OFS_BOARD_SEL, 32'h0000_002c);
        rdr(OFS_BOARD_SEL);
        `CHK(rd[15:0], CODE_REACH)
        rdr(OFS_STATUS);
        `CHK(rd[4], 1'b1)
        cond    <= '1;
        running <= 1'b1;
        wr(OFS_BOARD_SEL, {16'h0000, CODE_RSV_A});
        settle();
        `CHK(board, 1'b0)
        wr(OFS_BOARD_SEL, {16'h0000, CODE_RSV_B});
        settle();
        `CHK(board, 1'b0)
        cond <= 44'h800_0000_0000;
        wr(OFS_BOARD_SEL, {16'h0000, CODE_MAX});
        settle();
        `CHK(board, 1'b1)
        cond <= '0;
        wr(OFS_BOARD_SEL, {16'h0000, CODE_COMM});
        wr(OFS_COMM, 32'h0000_0001);
        settle();
        `CHK(board, 1'b1)
        wr(OFS_COMM, 32'h0000_0000);
        settle();
        `CHK(board, 1'b0)
        wr(OFS_CARD_SEL, {16'h0000, CODE_COMM});
        wr(OFS_COMM, 32'h0000_0002);
        settle();
        `CHK({card, board}, 2'h2)
        wr(8'h24, 32'h0000_ffff);
        rdr(8'h24);
        `CHK(rd, 32'h0000_0000)
    endtask : t_codes

    task automatic t_irq;
        running <= 1'b0;
        wr(OFS_BOARD_SEL, {16'h0000, CODE_NONE});
        wr(OFS_CARD_SEL, {16'h0000, CODE_RUN});
        wr(OFS_MASK, 32'h0000_0004);
        settle();
        rdr(OFS_STATUS);
        `CHK(irq, 1'b0)
        running <= 1'b1;
        settle();
        `CHK(irq, 1'b1)
        rdr(OFS_STATUS);
        `CHK(rd[4:0], 5'h04)
        @(posedge clk);
        `CHK(irq, 1'b0)
        rdr(OFS_MASK);
        `CHK(rd[4:0], 5'h04)
        wr(OFS_MASK, 32'h0000_0000);
        running <= 1'b0;
        settle();
        running <= 1'b1;
        settle();
        `CHK(irq, 1'b0)
        rdr(OFS_STATUS);
        `CHK(rd[3:2], 2'h3)
    endtask : t_irq

    // second reset in mid-run must bring the codes back after software changed them
    task automatic t_rst2;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdr(OFS_CARD_SEL);
        `CHK(rd[15:0], RST_CARD_SEL)
        rdr(OFS_BOARD_SEL);
        `CHK(rd[15:0], RST_BOARD_SEL)
        `CHK(card, 1'b0)
    endtask : t_rst2

    initial
    begin
        n_fail    = 0;
        cmp_count = 0;
        rst       = 1'b1;
        cyc       = 1'b0;
        stb       = 1'b0;
        we        = 1'b0;
        adr       = '0;
        sel       = 4'hf;
        wdat      = '0;
        running   = 1'b0;
        fault     = 1'b0;
        freq      = '0;
        target    = '0;
        maxf      = '0;
        cond      = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_run();
        t_fdt();
        t_reach();
        t_zero();
        t_codes();
        t_irq();
        t_rst2();
        tally_and_finish();
    end
endmodule : rofs_top_bench

// [src/rofs_fdt_hyst.sv]
/*
 frequency level detector with hysteresis: sets above the detect value,
 clears below detect value minus hysteresis. inputs synchronous to clk.
*/
`timescale 1ns/100ps
module rofs_fdt_hyst
    import rofs_pkg::*;
#(
    parameter int W = FREQ_W
)(
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] freq_i,
    input  wire logic [W-1:0] detect_i,
    input  wire logic [W-1:0] hyst_i,
    output logic              level_o
);
    logic         level_ff;
    logic         nxt_level;
    logic [W-1:0] clear_lvl;

    always_comb
    begin
        // hysteresis never exceeds the detect value, floor at zero anyway
        clear_lvl = (hyst_i > detect_i) ? '0 : detect_i - hyst_i;
        nxt_level = level_ff;
        if (freq_i > detect_i)
            nxt_level = 1'b1;
        else if (freq_i < clear_lvl)
            nxt_level = 1'b0;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            level_ff <= 1'b0;
        else
            level_ff <= nxt_level;
    end

    assign level_o = level_ff;
endmodule : rofs_fdt_hyst

// [src/rofs_pkg.sv]
/*
 relay output function selector: register map, codes, reset values, scaling.
 assumes a 32-bit classic wishbone slave port with word-aligned registers.
*/
package rofs_pkg;
    localparam int          FREQ_W        = 16;
    localparam int          CODE_W        = 16;
    localparam int          COND_N        = 44;
    localparam int          ADR_W         = 8;
    // ratios and widths are in 0.1 percent steps
    localparam int          RATIO_SCALE   = 1000;
    localparam logic [15:0] RATIO_MAX     = 16'h03e8;

    localparam logic [7:0]  OFS_BOARD_SEL = 8'h00;
    localparam logic [7:0]  OFS_CARD_SEL  = 8'h04;
    localparam logic [7:0]  OFS_DET_VAL   = 8'h08;
    localparam logic [7:0]  OFS_HYST      = 8'h0c;
    localparam logic [7:0]  OFS_REACH     = 8'h10;
    localparam logic [7:0]  OFS_COMM      = 8'h14;
    localparam logic [7:0]  OFS_STATUS    = 8'h18;
    localparam logic [7:0]  OFS_MASK      = 8'h1c;
    localparam logic [7:0]  OFS_LEVEL     = 8'h20;

    localparam logic [15:0] RST_BOARD_SEL = 16'h0002;
    localparam logic [15:0] RST_CARD_SEL  = 16'h0000;
    localparam logic [15:0] RST_DET_VAL   = 16'h0000;
    localparam logic [15:0] RST_HYST      = 16'h0000;
    localparam logic [15:0] RST_REACH     = 16'h0000;
    localparam logic [4:0]  RST_MASK      = 5'h00;

    localparam logic [15:0] CODE_NONE     = 16'h0000;
    localparam logic [15:0] CODE_RUN      = 16'h0001;
    localparam logic [15:0] CODE_FAULT    = 16'h0002;
    localparam logic [15:0] CODE_FREQ_LVL = 16'h0003;
    localparam logic [15:0] CODE_REACH    = 16'h0004;
    localparam logic [15:0] CODE_ZERO_RUN = 16'h0005;
    localparam logic [15:0] CODE_COMM     = 16'h0014;
    localparam logic [15:0] CODE_RSV_A    = 16'h0015;
    localparam logic [15:0] CODE_RSV_B    = 16'h0016;
    localparam logic [15:0] CODE_MAX      = 16'h002b;

    localparam int          ST_BOARD_RISE = 0;
    localparam int          ST_BOARD_FALL = 1;
    localparam int          ST_CARD_RISE  = 2;
    localparam int          ST_CARD_FALL  = 3;
    localparam int          ST_BAD_CODE   = 4;
    localparam int          ST_W          = 5;
endpackage : rofs_pkg

// [src/rofs_sel.sv]
/*
 one output function selector: picks one condition bit by function code.
 combinational; the caller registers the result.
*/
`timescale 1ns/100ps
module rofs_sel
    import rofs_pkg::*;
(
    input  wire logic [CODE_W-1:0] code_i,
    input  wire logic [COND_N-1:0] cond_i,
    input  wire logic              comm_i,
    output logic                   level_o
);
    always_comb
    begin
        if (code_i == CODE_COMM)
            level_o = comm_i;
        else if (code_i <= CODE_MAX)
            level_o = cond_i[code_i[5:0]];
        else
            level_o = 1'b0;
    end
endmodule : rofs_sel

// [src/rofs_top.sv]
/*
 relay output function selector top: wishbone registers, condition build,
 two selectors, registered relay levels, change interrupts.
 assumes all inputs synchronous to core_clk_i and a classic wishbone master.
*/
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/100ps
module rofs_top
    import rofs_pkg::*;
(
    input  wire logic              core_clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              drive_running_i,
    input  wire logic              fault_stop_i,
    input  wire logic [FREQ_W-1:0] run_freq_i,
    input  wire logic [FREQ_W-1:0] target_freq_i,
    input  wire logic [FREQ_W-1:0] max_freq_i,
    input  wire logic [COND_N-1:0] status_cond_i,
    output logic                   board_relay_output_o,
    output logic                   card_relay_output_o,
    output logic                   irq_o
);
    logic [CODE_W-1:0] board_sel_ff;
    logic [CODE_W-1:0] card_sel_ff;
    logic [FREQ_W-1:0] det_val_ff;
    logic [15:0]       hyst_ratio_ff;
    logic [15:0]       reach_w_ff;
    logic [1:0]        comm_ff;
    logic [ST_W-1:0]   status_ff;
    logic [ST_W-1:0]   mask_ff;
    logic              ack_ff;
    logic [31:0]       rdat_ff;
    logic              board_ff;
    logic              card_ff;
    logic              irq_ff;

    logic              req;
    logic              wr_ev;
    logic              rd_ev;
    logic [15:0]       wr_half;
    logic [15:0]       cur_half;
    logic [15:0]       nxt_half;
    logic              bad_code;
    logic [31:0]       nxt_rdat;
    logic [ST_W-1:0]   nxt_status;
    logic [ST_W-1:0]   st_set;
    logic              nxt_board;
    logic              nxt_card;
    logic [31:0]       hyst_prod;
    logic [FREQ_W-1:0] hyst_abs;
    logic [31:0]       reach_prod;
    logic [FREQ_W:0]   reach_abs;
    logic [FREQ_W:0]   reach_lo;
    logic [FREQ_W:0]   reach_hi;
    logic              reach_in;
    logic              fdt_level;
    logic              zero_run;
    logic [COND_N-1:0] cond_vec;

    // bus: one-cycle registered answer, ack drops the cycle after
    assign req   = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr_ev = req & wb_we_i;
    assign rd_ev = req & ~wb_we_i;
    assign wr_half = wb_dat_i[15:0];

    always_comb
    begin
        case (wb_adr_i)
            OFS_BOARD_SEL: cur_half = board_sel_ff;
            OFS_CARD_SEL:  cur_half = card_sel_ff;
            OFS_DET_VAL:   cur_half = det_val_ff;
            OFS_HYST:      cur_half = hyst_ratio_ff;
            OFS_REACH:     cur_half = reach_w_ff;
            default:       cur_half = 16'h0000;
        endcase
        nxt_half[7:0]  = wb_sel_i[0] ? wr_half[7:0]  : cur_half[7:0];
        nxt_half[15:8] = wb_sel_i[1] ? wr_half[15:8] : cur_half[15:8];
    end

    // codes above the top of the table are refused and flagged
    assign bad_code = wr_ev && (wb_adr_i == OFS_BOARD_SEL || wb_adr_i == OFS_CARD_SEL)
                      && (nxt_half > CODE_MAX);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            ack_ff <= 1'b0;
        else
            ack_ff <= req;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            board_sel_ff <= RST_BOARD_SEL;
            card_sel_ff  <= RST_CARD_SEL;
        end
        else if (wr_ev && !bad_code)
        begin
            if (wb_adr_i == OFS_BOARD_SEL)
                board_sel_ff <= nxt_half;
            if (wb_adr_i == OFS_CARD_SEL)
                card_sel_ff <= nxt_half;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            det_val_ff    <= RST_DET_VAL;
            hyst_ratio_ff <= RST_HYST;
            reach_w_ff    <= RST_REACH;
        end
        else if (wr_ev)
        begin
            if (wb_adr_i == OFS_DET_VAL)
                det_val_ff <= nxt_half;
            // ratios clamp at 100 percent so thresholds stay in range
            if (wb_adr_i == OFS_HYST)
                hyst_ratio_ff <= (nxt_half > RATIO_MAX) ? RATIO_MAX : nxt_half;
            if (wb_adr_i == OFS_REACH)
                reach_w_ff <= (nxt_half > RATIO_MAX) ? RATIO_MAX : nxt_half;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            comm_ff <= 2'b00;
        else if (wr_ev && wb_adr_i == OFS_COMM && wb_sel_i[0])
            comm_ff <= wb_dat_i[1:0];
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            mask_ff <= RST_MASK;
        else if (wr_ev && wb_adr_i == OFS_MASK && wb_sel_i[0])
            mask_ff <= wb_dat_i[ST_W-1:0];
    end

    always_comb
    begin
        case (wb_adr_i)
            OFS_BOARD_SEL: nxt_rdat = {16'h0000, board_sel_ff};
            OFS_CARD_SEL:  nxt_rdat = {16'h0000, card_sel_ff};
            OFS_DET_VAL:   nxt_rdat = {16'h0000, det_val_ff};
            OFS_HYST:      nxt_rdat = {16'h0000, hyst_ratio_ff};
            OFS_REACH:     nxt_rdat = {16'h0000, reach_w_ff};
            OFS_COMM:      nxt_rdat = {30'h00000000, comm_ff};
            OFS_STATUS:    nxt_rdat = {27'h0000000, status_ff};
            OFS_MASK:      nxt_rdat = {27'h0000000, mask_ff};
            OFS_LEVEL:     nxt_rdat = {29'h00000000, fdt_level, card_ff, board_ff};
            default:       nxt_rdat = 32'h00000000;
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            rdat_ff <= 32'h00000000;
        else if (rd_ev)
            rdat_ff <= nxt_rdat;
    end

    // threshold arithmetic
    always_comb
    begin
        hyst_prod  = 32'(det_val_ff) * 32'(hyst_ratio_ff);
        hyst_abs   = FREQ_W'(hyst_prod / 32'(RATIO_SCALE));
        reach_prod = 32'(max_freq_i) * 32'(reach_w_ff);
        reach_abs  = (FREQ_W+1)'(reach_prod / 32'(RATIO_SCALE));
        reach_lo   = ({1'b0, target_freq_i} > reach_abs) ? {1'b0, target_freq_i} - reach_abs : '0;
        reach_hi   = {1'b0, target_freq_i} + reach_abs;
        reach_in   = ({1'b0, run_freq_i} >= reach_lo) && ({1'b0, run_freq_i} <= reach_hi);
        zero_run   = drive_running_i && (run_freq_i == '0);
    end

    rofs_fdt_hyst #(
        .W        (FREQ_W)
    ) u_fdt (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .freq_i     (run_freq_i),
        .detect_i   (det_val_ff),
        .hyst_i     (hyst_abs),
        .level_o    (fdt_level)
    );

    always_comb
    begin
        cond_vec                     = status_cond_i;
        cond_vec[CODE_NONE[5:0]]     = 1'b0;
        cond_vec[CODE_RUN[5:0]]      = drive_running_i;
        cond_vec[CODE_FAULT[5:0]]    = fault_stop_i;
        cond_vec[CODE_FREQ_LVL[5:0]] = fdt_level;
        cond_vec[CODE_REACH[5:0]]    = reach_in;
        cond_vec[CODE_ZERO_RUN[5:0]] = zero_run;
        cond_vec[CODE_COMM[5:0]]     = 1'b0;
        cond_vec[CODE_RSV_A[5:0]]    = 1'b0;
        cond_vec[CODE_RSV_B[5:0]]    = 1'b0;
    end

    rofs_sel u_board_sel (
        .code_i  (board_sel_ff),
        .cond_i  (cond_vec),
        .comm_i  (comm_ff[0]),
        .level_o (nxt_board)
    );

    rofs_sel u_card_sel (
        .code_i  (card_sel_ff),
        .cond_i  (cond_vec),
        .comm_i  (comm_ff[1]),
        .level_o (nxt_card)
    );

    // registered so a code change never glitches the relay drive
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            board_ff <= 1'b0;
            card_ff  <= 1'b0;
        end
        else
        begin
            board_ff <= nxt_board;
            card_ff  <= nxt_card;
        end
    end

    // interrupts: edges of each output plus refused code writes
    always_comb
    begin
        st_set                = '0;
        st_set[ST_BOARD_RISE] = nxt_board & ~board_ff;
        st_set[ST_BOARD_FALL] = ~nxt_board & board_ff;
        st_set[ST_CARD_RISE]  = nxt_card & ~card_ff;
        st_set[ST_CARD_FALL]  = ~nxt_card & card_ff;
        st_set[ST_BAD_CODE]   = bad_code;
        // a read clears, but an event in the same cycle survives
        nxt_status = ((rd_ev && wb_adr_i == OFS_STATUS) ? '0 : status_ff) | st_set;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            status_ff <= '0;
        else
            status_ff <= nxt_status;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(nxt_status & mask_ff);
    end

    assign wb_ack_o             = ack_ff;
    assign wb_dat_o             = rdat_ff;
    assign board_relay_output_o = board_ff;
    assign card_relay_output_o  = card_ff;
    assign irq_o                = irq_ff;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    reset_codes_a: assert property (disable iff (1'b0)
        rst_i |=> board_sel_ff == RST_BOARD_SEL && card_sel_ff == RST_CARD_SEL)
        else $error("selector codes not at reset values");

    code_range_a: assert property (
        board_sel_ff <= CODE_MAX && card_sel_ff <= CODE_MAX)
        else $error("selector holds a code above the table");

    reserved_off_a: assert property (
        (board_sel_ff == CODE_RSV_A || board_sel_ff == CODE_RSV_B) |=> !board_relay_output_o)
        else $error("reserved code drove the output");

    no_output_a: assert property (
        card_sel_ff == CODE_NONE |=> !card_relay_output_o)
        else $error("code zero left the output active");

    run_follow_a: assert property (
        board_sel_ff == CODE_RUN |=> board_relay_output_o == $past(drive_running_i))
        else $error("running output does not follow run state");

    fault_follow_a: assert property (
        board_sel_ff == CODE_FAULT |=> board_relay_output_o == $past(fault_stop_i))
        else $error("fault output does not follow fault stop");

    fdt_set_a: assert property (
        run_freq_i > det_val_ff |=> fdt_level)
        else $error("level detect did not set above value");

    fdt_hold_a: assert property (
        fdt_level && run_freq_i >= det_val_ff - hyst_abs && hyst_abs <= det_val_ff |=> fdt_level)
        else $error("level detect cleared inside hysteresis band");

    fdt_clear_a: assert property (
        !(run_freq_i > det_val_ff) && run_freq_i < det_val_ff - hyst_abs
        && hyst_abs <= det_val_ff |=> !fdt_level)
        else $error("level detect did not clear below band");

    reach_out_a: assert property (
        board_sel_ff == CODE_REACH |=> board_relay_output_o == $past(reach_in))
        else $error("reach output wrong");

    zero_stop_a: assert property (
        board_sel_ff == CODE_ZERO_RUN && !drive_running_i |=> !board_relay_output_o)
        else $error("zero-speed output active while stopped");

    zero_run_a: assert property (
        card_sel_ff == CODE_ZERO_RUN && drive_running_i && run_freq_i == '0 |=> card_relay_output_o)
        else $error("zero-speed output inactive at zero running");

    comm_follow_a: assert property (
        card_sel_ff == CODE_COMM |=> card_relay_output_o == $past(comm_ff[1]))
        else $error("comm output does not follow host bit");

    code_switch_a: assert property (
        $changed(card_sel_ff) && card_sel_ff == CODE_RUN |=> card_relay_output_o == $past(drive_running_i))
        else $error("output not updated one clock after code change");

    ack_pulse_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single cycle after request");

    irq_mask_a: assert property (
        $past(|(nxt_status & mask_ff)) |-> irq_o)
        else $error("unmasked status did not raise interrupt");

    board_rise_c: cover property (board_sel_ff == CODE_RUN ##1 $rose(board_relay_output_o));
    fdt_cycle_c:  cover property ($rose(fdt_level) ##[1:50] $fell(fdt_level));
    comm_card_c:  cover property (card_sel_ff == CODE_COMM ##1 $rose(card_relay_output_o));
    bad_code_c:   cover property (bad_code ##1 irq_o);
endmodule : rofs_top
